// *** bench/edps_src.sv ***
// Bit source model standing for the device under test
`timescale 1ns/100ps
module edps_src (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic err,
	input wire logic [31:0] pat,
	output edps_pkg::edps_rx_t rx
);
	logic [4:0] idx_q;
	// Idle line toggles so a stale level never passes for a bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idx_q <= 5'h00;
			rx <= '0;
		end else if (en) begin
			rx.valid <= 1'b1;
			rx.data <= pat[idx_q] ^ err;
			idx_q <= idx_q + 5'h01;
		end else begin
			rx.valid <= 1'b0;
			rx.data <= ~rx.data;
		end
	end
endmodule

// *** bench/edps_top_tb.sv ***
// Self-checking bench for the pattern sync and error accounting block
`timescale 1ns/100ps
module edps_top_tb;
	// Short interval keeps the run brief; interval times follow from it, the clock loss time does not
	localparam int unsigned INTV = 50;
	// Frame bits B5 framed by zeros occur once per period
	localparam logic [31:0] PAT = 32'h000000B5;
	localparam logic [31:0] GO = 32'h00000001;
	localparam logic [31:0] RJ = 32'h00000010;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	logic sync_ok;
	logic src_en = 1'b0;
	logic src_err = 1'b0;
	edps_pkg::edps_rx_t rx;
	int n_fail = 0;
	int n_tests = 0;

	edps_top #(.INTV_CYC(INTV)) u_edps_top (.CORE_CLK(core_clk), .RST(rst),
		.CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
		.RX(rx), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.IRQ(irq), .SYNC_OK(sync_ok));
	edps_src u_edps_src (.clk(core_clk), .rst(rst), .en(src_en),
		.err(src_err), .pat(PAT), .rx(rx));

	initial begin
		forever #25 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] eff_len(input logic [31:0] l);
		logic [31:0] e;
		e = l;
		while (e < 32'h00000200) e = e + l;
		return e;
	endfunction
	// Frame bit 0 is the last received, reference bits from position 1
	function automatic logic [31:0] fpat_of(input int flen);
		logic [31:0] f;
		f = 32'h00000000;
		for (int i = 0; i < flen; i++) f[i] = PAT[flen - 1 - i];
		return f;
	endfunction
	function automatic logic [11:0] ca(input int i);
		return edps_pkg::A_CNT + 12'(4 * i);
	endfunction
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("Tests %0d, failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t: %s got %h exp %h", $time, what, got,
				exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h00000, a};
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic get(input logic [11:0] a, output logic [31:0] v);
		bus(1'b0, a, 32'h00000000, v);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] x;
		get(a, x);
		chk(x & m, e, "register");
	endtask
	task automatic cfgw(input logic [31:0] c, input logic [31:0] pl,
		input logic [31:0] fl, input logic [31:0] fp);
		wr(edps_pkg::A_CFG, c);
		wr(edps_pkg::A_PLEN, pl);
		wr(edps_pkg::A_FLEN, fl);
		wr(edps_pkg::A_FPOS, fp);
	endtask
	task automatic wait_sync;
		for (int k = 0; k < 3000 && sync_ok !== 1'b1; k++) @(posedge core_clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		$display("CHECK FAILED %0t: run did not finish", $time);
		report_and_stop();
	end

	initial begin
		logic [31:0] v;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] rj_tab [10];
		logic [31:0] ef_tab [5];
		int n;
		// Packed {cfg, flen, fpos}, each start must be refused
		// Large positions lie one step past the last frame start that fits the repeated 512-bit length
		// Combined cases program the 64-bit frame
		rj_tab = '{32'h00080001, 32'h01080001, 32'h07080001, 32'h04060001,
			32'h04440001, 32'h04000001, 32'h04080000, 32'h040801FA,
			32'h0C400002, 32'h0C4001C3};
		// Packed {cfg, plen, rlen}
		ef_tab = '{32'h0400C000, 32'h041FF000, 32'h04200000, 32'h06200064,
			32'h02028000};
		void'($urandom(32'h05B93688));
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		rdc(edps_pkg::A_CFG, 32'hFFFFFFFF, 32'h00000000);
		rdc(edps_pkg::A_STAT, 32'hFFFFFFFF, 32'h00000000);
		rdc(edps_pkg::A_IND, 32'hFFFFFFFF, 32'h00000000);
		rdc(12'h200, 32'hFFFFFFFF, 32'h00000000);
		chk({30'h0, irq, sync_ok | hresp}, 32'h0, "reset outputs");
		wr(edps_pkg::A_REF, PAT);
		wr(edps_pkg::A_FPL, fpat_of(8));
		wr(edps_pkg::A_FPH, 32'h00000000);
		for (int i = 0; i < 10; i++) begin
			cfgw(32'(rj_tab[i][31:24]), 32'h20, 32'(rj_tab[i][23:16]),
				32'(rj_tab[i][15:0]));
			wr(edps_pkg::A_MASK, i[0] ? 32'h0 : RJ);
			wr(edps_pkg::A_CMD, GO);
			repeat (40) @(posedge core_clk);
			rdc(edps_pkg::A_STAT, RJ, RJ);
			chk({31'h0, irq}, {31'h0, ~i[0]}, "irq");
			wr(edps_pkg::A_STAT, RJ);
			rdc(edps_pkg::A_STAT, RJ, 32'h0);
			chk({31'h0, irq}, 32'h0, "irq clear");
		end
		for (int i = 0; i < 5; i++) begin
			cfgw(32'(ef_tab[i][31:24]), 32'(ef_tab[i][23:12]), 32'h8, 32'h1);
			wr(edps_pkg::A_RLEN, 32'(ef_tab[i][11:0]));
			wr(edps_pkg::A_CMD, GO);
			repeat (150) @(posedge core_clk);
			a = (ef_tab[i][26:25] == 2'h3) ? 32'(ef_tab[i][11:0])
				: 32'(ef_tab[i][23:12]);
			rdc(edps_pkg::A_EFF, 32'hFFFFFFFF, eff_len(a));
			rdc(edps_pkg::A_STAT, RJ, 32'h0);
			wr(edps_pkg::A_CMD, 32'h2);
		end
		src_en <= 1'b1;
		for (int m = 0; m < 2; m++) begin
			cfgw(32'h4 | 32'(m << 4), 32'h20, 32'h8, 32'h1);
			wr(edps_pkg::A_STAT, 32'h3F);
			wr(edps_pkg::A_CMD, GO);
			wait_sync();
			chk({31'h0, sync_ok}, 32'h1, "sync");
			rdc(edps_pkg::A_IND, 32'h100, 32'h100);
			n = 1 + $urandom % 6;
			for (int k = 0; k < n; k++) begin
				@(posedge core_clk);
				src_err <= 1'b1;
				@(posedge core_clk);
				src_err <= 1'b0;
				repeat (2 + $urandom % 8) @(posedge core_clk);
			end
			wr(edps_pkg::A_CMD, 32'h4);
			rdc(edps_pkg::A_IND, 32'h77, 32'h44);
			rdc(ca(edps_pkg::C_TOT), 32'hFFFFFFFF, 32'(n));
			get(ca(edps_pkg::C_A), a);
			get(ca(edps_pkg::C_B), b);
			chk(a + b, 32'(n), "split counts");
			// Let the current interval close so its errors are counted
			repeat (INTV) @(posedge core_clk);
			get(ca(edps_pkg::C_EI), v);
			chk({31'h0, v != 0 && v <= n}, 32'h1, "errored intervals");
			chk({31'h0, sync_ok}, 32'h1, "sync kept");
			src_en <= 1'b0;
			repeat (260) @(posedge core_clk);
			chk({31'h0, sync_ok}, 32'h0, "sync lost");
			rdc(edps_pkg::A_IND, 32'h13, 32'h13);
			rdc(edps_pkg::A_STAT, 32'hA, 32'hA);
			src_en <= 1'b1;
			repeat (30) @(posedge core_clk);
			rdc(edps_pkg::A_IND, 32'h11, 32'h10);
			get(ca(edps_pkg::C_CLI), a);
			get(ca(edps_pkg::C_SLI), b);
			chk({30'h0, a != 0, b != 0}, 32'h3, "alarm intervals");
			get(ca(edps_pkg::C_CCNT), v);
			chk({31'h0, v != 0}, 32'h1, "clock count");
			wr(edps_pkg::A_CMD, 32'h2);
		end
		cfgw(32'h5, 32'h20, 32'h8, 32'h1);
		wr(edps_pkg::A_STAT, 32'h3F);
		wr(edps_pkg::A_CMD, GO);
		wait_sync();
		chk({31'h0, sync_ok}, 32'h1, "quick sync");
		rdc(edps_pkg::A_IND, 32'h300, 32'h300);
		wr(edps_pkg::A_CMD, 32'h2);
		wr(edps_pkg::A_PER, 32'h3);
		wr(edps_pkg::A_STAT, 32'h3F);
		wr(edps_pkg::A_CMD, GO);
		repeat (40) @(posedge core_clk);
		rdc(edps_pkg::A_IND, 32'h200, 32'h200);
		get(ca(edps_pkg::C_STIME), v);
		chk({31'h0, v != 0}, 32'h1, "start time");
		repeat (300) @(posedge core_clk);
		rdc(edps_pkg::A_STAT, 32'h20, 32'h20);
		rdc(edps_pkg::A_IND, 32'h200, 32'h0);
		rdc(ca(edps_pkg::C_ELAP), 32'hFFFFFFFF, 32'h3);
		rdc(edps_pkg::A_REM, 32'hFFFFFFFF, 32'h0);
		report_and_stop();
	end
endmodule

// *** hdl/edps_pkg.sv ***
// Constants and types for the pattern sync and error accounting block
package edps_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
	localparam int unsigned INTV_US = 1_000;
	localparam int unsigned INTV_CYC = INTV_US * 1_000 / CLK_NS;
	localparam int unsigned LOSS_NS = 10_000;
	localparam int unsigned LOSS_CYC = (LOSS_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] LOSS_CNT = 8'(LOSS_CYC);
	localparam logic [3:0] SLIP_ERRS = 4'h8;
	localparam logic [16:0] MIN_DET = 17'h00200;
	localparam logic [6:0] FLEN_MIN = 7'h04;
	localparam logic [6:0] FLEN_MAX = 7'h40;
	localparam logic [15:0] PLEN_MIN = 16'h0004;
	localparam logic [15:0] PLEN_MAX = 16'h0200;
	localparam int unsigned REF_WORDS = 16;
	localparam int unsigned SR_BITS = 128;
	////////////////////////////////////////////////////////////////////////
	localparam logic [11:0] A_CMD = 12'h000;
	localparam logic [11:0] A_CFG = 12'h004;
	localparam logic [11:0] A_FLEN = 12'h008;
	localparam logic [11:0] A_FPOS = 12'h00C;
	localparam logic [11:0] A_PLEN = 12'h010;
	localparam logic [11:0] A_RLEN = 12'h014;
	localparam logic [11:0] A_FPL = 12'h018;
	localparam logic [11:0] A_FPH = 12'h01C;
	localparam logic [11:0] A_PER = 12'h020;
	localparam logic [11:0] A_STAT = 12'h024;
	localparam logic [11:0] A_MASK = 12'h028;
	localparam logic [11:0] A_IND = 12'h02C;
	localparam logic [11:0] A_CNT = 12'h030;
	localparam logic [11:0] A_REM = 12'h05C;
	localparam logic [11:0] A_EFF = 12'h060;
	localparam logic [11:0] A_REF = 12'h100;
	////////////////////////////////////////////////////////////////////////
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_HRST = 2;
	localparam int CF_QUICK = 0;
	localparam int CF_PT_LO = 1;
	localparam int CF_PT_HI = 2;
	localparam int CF_COMBO = 3;
	localparam int CF_METH = 4;
	localparam int CF_W = 5;
	localparam logic [1:0] PT_PRBS = 2'h0;
	localparam logic [1:0] PT_ZERO = 2'h1;
	localparam logic [1:0] PT_DATA = 2'h2;
	localparam logic [1:0] PT_MIXED = 2'h3;
	localparam int IRQ_SGAIN = 0;
	localparam int IRQ_SLOSS = 1;
	localparam int IRQ_ERR = 2;
	localparam int IRQ_CLK = 3;
	localparam int IRQ_CFG = 4;
	localparam int IRQ_DONE = 5;
	localparam int NIRQ = 6;
	localparam int I_CLK = 0;
	localparam int I_SYNC = 1;
	localparam int I_ERR = 2;
	localparam int IND_HIST = 4;
	localparam int IND_SOK = 8;
	localparam int IND_RUN = 9;
	localparam int C_TOT = 0;
	localparam int C_A = 1;
	localparam int C_B = 2;
	localparam int C_EI = 3;
	localparam int C_EFI = 4;
	localparam int C_CLI = 5;
	localparam int C_SLI = 6;
	localparam int C_CCNT = 7;
	localparam int C_FREQ = 8;
	localparam int C_ELAP = 9;
	localparam int C_STIME = 10;
	localparam int NCNT = 11;
	////////////////////////////////////////////////////////////////////////
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_SETUP = 5'h02,
		S_HUNT = 5'h04,
		S_ALIGN = 5'h08,
		S_SYNC = 5'h10
	} edps_state_t;

	typedef struct packed {
		logic valid;
		logic data;
	} edps_rx_t;

	typedef struct packed {
		edps_state_t state;
		logic [CF_W-1:0] cfg;
		logic [6:0] flen;
		logic [15:0] fpos;
		logic [15:0] plen;
		logic [15:0] rlen;
		logic [63:0] fpat;
		logic [31:0] period;
		logic [NIRQ-1:0] status;
		logic [NIRQ-1:0] mask;
		logic [REF_WORDS-1:0][31:0] refm;
		logic [SR_BITS-1:0] sr;
		logic [15:0] ptr;
		logic [16:0] eff;
		logic run;
		logic pexp;
		logic ie;
		logic icl;
		logic isl;
		logic lerr;
		logic [2:0] hist;
		logic [3:0] errrun;
		logic [7:0] lossc;
		logic [31:0] tcnt;
		logic [31:0] fbits;
		logic [31:0] tms;
		logic [NCNT-1:0][31:0] cnt;
		logic ap_v;
		logic ap_w;
		logic [11:0] ap_a;
		logic [31:0] rdata;
	} edps_st_t;

	localparam edps_st_t ST_RST = '{state: S_IDLE, default: '0};
endpackage

// *** hdl/edps_top.sv ***
// Frame/quick pattern sync, error and alarm accounting, AHB-Lite slave
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
module edps_top #(
	parameter int unsigned INTV_CYC = edps_pkg::INTV_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire edps_pkg::edps_rx_t RX,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic IRQ,
	output logic SYNC_OK
);
	edps_pkg::edps_st_t q;
	edps_pkg::edps_st_t d;
	logic [edps_pkg::SR_BITS-1:0] fexp;
	logic [edps_pkg::SR_BITS-1:0] mism;
	logic [7:0] mlen;
	logic hit;
	logic [15:0] dlen;
	logic mode_ok;
	logic flen_ok;
	logic plen_ok;
	logic cfg_ok;
	logic pos_ok;
	logic [16:0] room;
	logic quick;
	logic [511:0] refv;
	logic exp_bit;
	logic err_now;
	logic clk_loss;
	logic tick;
	logic wr;
	logic start;
	logic stop;
	logic hrst;
	logic [2:0] cur;
	localparam int NIRQ_W = edps_pkg::NIRQ;
	logic [NIRQ_W-1:0] ev;
	logic [NIRQ_W-1:0] w1c;
	logic [15:0] nx;
	logic [31:0] rd;
	logic [9:0] ci;

	////////////////////////////////////////////////////////////////////////
	assign quick = q.cfg[edps_pkg::CF_QUICK];
	assign mlen = q.cfg[edps_pkg::CF_COMBO] ? {q.flen, 1'b0}
		: {1'b0, q.flen};
	assign dlen = (q.cfg[edps_pkg::CF_PT_HI:edps_pkg::CF_PT_LO]
		== edps_pkg::PT_MIXED) ? q.rlen : q.plen;

	always_comb begin
		case (q.cfg[edps_pkg::CF_PT_HI:edps_pkg::CF_PT_LO])
			edps_pkg::PT_ZERO: mode_ok = 1'b1;
			edps_pkg::PT_DATA: mode_ok = 1'b1;
			edps_pkg::PT_MIXED: mode_ok = ~quick;
			default: mode_ok = 1'b0;
		endcase
	end

	assign flen_ok = (q.flen >= edps_pkg::FLEN_MIN)
		&& (q.flen <= edps_pkg::FLEN_MAX) && (q.flen[1:0] == 2'h0);
	// Reference memory bounds the usable pattern length
	assign plen_ok = (q.plen >= edps_pkg::PLEN_MIN)
		&& (q.plen <= edps_pkg::PLEN_MAX) && (dlen >= edps_pkg::PLEN_MIN);
	assign cfg_ok = mode_ok && plen_ok && (quick || flen_ok);

	assign room = 17'(q.eff - {10'h000, q.flen});
	always_comb begin
		if (q.eff < {10'h000, q.flen}) begin
			pos_ok = 1'b0;
		end else if (q.cfg[edps_pkg::CF_COMBO]) begin
			pos_ok = q.fpos[0]
				&& ({2'b00, q.fpos[15:1]} <= {1'b0, room[16:1]});
		end else begin
			pos_ok = (q.fpos != 16'h0000)
				&& ({1'b0, q.fpos} <= 17'(room + 17'h00001));
		end
	end

	// In combination each frame bit appears once per channel, interleaved
	genvar j;
	for (j = 0; j < edps_pkg::SR_BITS; j++) begin : g_frame
		if (j < 64) begin : g_lo
			assign fexp[j] = q.cfg[edps_pkg::CF_COMBO] ? q.fpat[j / 2]
				: q.fpat[j];
		end else begin : g_hi
			assign fexp[j] = q.fpat[j / 2];
		end
		assign mism[j] = (8'(j) < mlen) && (q.sr[j] != fexp[j]);
	end
	assign hit = ~|mism;

	assign refv = q.refm;
	assign exp_bit = refv[q.ptr[8:0]];
	assign err_now = q.run && (q.state == edps_pkg::S_SYNC) && RX.valid
		&& (RX.data != exp_bit);
	assign clk_loss = q.lossc == edps_pkg::LOSS_CNT;
	assign tick = q.tcnt == 32'(INTV_CYC - 1);
	assign cur[edps_pkg::I_CLK] = clk_loss;
	assign cur[edps_pkg::I_SYNC] = q.run
		&& (q.state != edps_pkg::S_SYNC);
	assign cur[edps_pkg::I_ERR] = q.lerr || q.ie;

	////////////////////////////////////////////////////////////////////////
	assign wr = q.ap_v && q.ap_w;
	assign start = wr && (q.ap_a == edps_pkg::A_CMD)
		&& HWDATA[edps_pkg::CMD_START];
	assign stop = wr && (q.ap_a == edps_pkg::A_CMD)
		&& HWDATA[edps_pkg::CMD_STOP];
	assign hrst = wr && (q.ap_a == edps_pkg::A_CMD)
		&& HWDATA[edps_pkg::CMD_HRST];
	assign ci = 10'((HADDR[11:0] - edps_pkg::A_CNT) >> 2);

	always_comb begin
		rd = 32'h00000000;
		case (HADDR[11:0])
			edps_pkg::A_CFG: rd = 32'(q.cfg);
			edps_pkg::A_FLEN: rd = 32'(q.flen);
			edps_pkg::A_FPOS: rd = 32'(q.fpos);
			edps_pkg::A_PLEN: rd = 32'(q.plen);
			edps_pkg::A_RLEN: rd = 32'(q.rlen);
			edps_pkg::A_FPL: rd = q.fpat[31:0];
			edps_pkg::A_FPH: rd = q.fpat[63:32];
			edps_pkg::A_PER: rd = q.period;
			edps_pkg::A_STAT: rd = 32'(q.status);
			edps_pkg::A_MASK: rd = 32'(q.mask);
			edps_pkg::A_IND: begin
				rd[2:0] = cur;
				rd[edps_pkg::IND_HIST +: 3] = q.hist;
				rd[edps_pkg::IND_SOK] = q.state == edps_pkg::S_SYNC;
				rd[edps_pkg::IND_RUN] = q.run;
			end
			edps_pkg::A_REM: begin
				if (q.period != 32'h00000000) begin
					rd = 32'(q.period - q.cnt[edps_pkg::C_ELAP]);
				end
			end
			edps_pkg::A_EFF: rd = 32'(q.eff);
			default: begin
				if (HADDR[11:6] == edps_pkg::A_REF[11:6]) begin
					rd = q.refm[HADDR[5:2]];
				end else if (HADDR[11:0] >= edps_pkg::A_CNT
					&& ci < 10'(edps_pkg::NCNT)) begin
					rd = q.cnt[ci];
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		ev = '0;
		w1c = '0;
		nx = q.ptr;
		d.ap_v = HSEL && HTRANS[1] && HREADY;
		d.ap_w = HWRITE;
		d.ap_a = HADDR[11:0];
		if (HSEL && HTRANS[1] && HREADY && !HWRITE) begin
			d.rdata = rd;
		end
		// Settings except the interrupt mask, and the reference, are frozen while a measurement runs
		if (wr) begin
			case (q.ap_a)
				edps_pkg::A_STAT: w1c = HWDATA[NIRQ_W-1:0];
				edps_pkg::A_MASK: d.mask = HWDATA[NIRQ_W-1:0];
				default: begin
					if (q.state == edps_pkg::S_IDLE) begin
						case (q.ap_a)
							edps_pkg::A_CFG: d.cfg = HWDATA[4:0];
							edps_pkg::A_FLEN: d.flen = HWDATA[6:0];
							edps_pkg::A_FPOS: d.fpos = HWDATA[15:0];
							edps_pkg::A_PLEN: d.plen = HWDATA[15:0];
							edps_pkg::A_RLEN: d.rlen = HWDATA[15:0];
							edps_pkg::A_FPL: d.fpat[31:0] = HWDATA;
							edps_pkg::A_FPH: d.fpat[63:32] = HWDATA;
							edps_pkg::A_PER: d.period = HWDATA;
							default: begin
								if (q.ap_a[11:6] == edps_pkg::A_REF[11:6]) begin
									d.refm[q.ap_a[5:2]] = HWDATA;
								end
							end
						endcase
					end
				end
			endcase
		end

		if (RX.valid) begin
			d.sr = {q.sr[edps_pkg::SR_BITS-2:0], RX.data};
			d.lossc = 8'h00;
		end else if (!clk_loss) begin
			d.lossc = 8'(q.lossc + 8'h01);
		end
		if (clk_loss && (q.lossc != edps_pkg::LOSS_CNT - 8'h01)) begin
			ev[edps_pkg::IRQ_CLK] = 1'b0;
		end
		if (!clk_loss && !RX.valid
			&& (q.lossc == edps_pkg::LOSS_CNT - 8'h01)) begin
			ev[edps_pkg::IRQ_CLK] = 1'b1;
		end

		// Free gate: frequency in kHz is bits per 1 ms interval
		d.tcnt = tick ? 32'h00000000 : 32'(q.tcnt + 32'h1);
		d.fbits = tick ? 32'h00000000 : 32'(q.fbits + 32'(RX.valid));
		if (tick) begin
			d.cnt[edps_pkg::C_FREQ] = 32'(q.fbits + 32'(RX.valid));
			d.tms = 32'(q.tms + 32'h1);
		end

		case (q.state)
			edps_pkg::S_IDLE: begin
				d.run = 1'b0;
			end
			edps_pkg::S_SETUP: begin
				if (q.eff < edps_pkg::MIN_DET) begin
					d.eff = 17'(q.eff + {1'b0, dlen});
				end else if (quick || pos_ok) begin
					d.state = edps_pkg::S_HUNT;
				end else begin
					d.state = edps_pkg::S_IDLE;
					d.run = 1'b0;
					ev[edps_pkg::IRQ_CFG] = 1'b1;
				end
			end
			edps_pkg::S_HUNT: begin
				if (quick) begin
					d.state = edps_pkg::S_SYNC;
					d.ptr = 16'h0000;
					d.errrun = 4'h0;
					ev[edps_pkg::IRQ_SGAIN] = 1'b1;
				end else if (hit) begin
					d.state = edps_pkg::S_ALIGN;
					d.ptr = 16'(q.fpos - 16'h0001 + {8'h00, mlen}
						+ {15'h0000, RX.valid});
				end
			end
			edps_pkg::S_ALIGN: begin
				// Pattern wraps modulo its length, one subtraction per cycle
				nx = 16'(q.ptr + {15'h0000, RX.valid});
				if (nx >= q.plen) begin
					nx = 16'(nx - q.plen);
				end
				d.ptr = nx;
				if (nx < q.plen) begin
					d.state = edps_pkg::S_SYNC;
					d.errrun = 4'h0;
					ev[edps_pkg::IRQ_SGAIN] = 1'b1;
				end
			end
			edps_pkg::S_SYNC: begin
				if (RX.valid) begin
					d.pexp = exp_bit;
					d.ptr = (q.ptr == 16'(q.plen - 16'h0001)) ? 16'h0000
						: 16'(q.ptr + 16'h0001);
					d.errrun = (RX.data != exp_bit)
						? 4'(q.errrun + 4'h1) : 4'h0;
				end
				if (clk_loss || (RX.valid && (RX.data != exp_bit)
					&& (q.errrun == edps_pkg::SLIP_ERRS - 4'h1))) begin
					d.state = edps_pkg::S_HUNT;
					ev[edps_pkg::IRQ_SLOSS] = q.run;
				end
			end
			default: begin
				d.state = edps_pkg::S_IDLE;
				d.run = 1'b0;
			end
		endcase

		if (err_now) begin
			d.ie = 1'b1;
			ev[edps_pkg::IRQ_ERR] = 1'b1;
			d.cnt[edps_pkg::C_TOT] = 32'(q.cnt[edps_pkg::C_TOT] + 32'h1);
			if (q.cfg[edps_pkg::CF_METH] ? (exp_bit != q.pexp)
				: RX.data) begin
				d.cnt[edps_pkg::C_A] = 32'(q.cnt[edps_pkg::C_A] + 32'h1);
			end else begin
				d.cnt[edps_pkg::C_B] = 32'(q.cnt[edps_pkg::C_B] + 32'h1);
			end
		end
		if (q.run && RX.valid) begin
			d.cnt[edps_pkg::C_CCNT] = 32'(q.cnt[edps_pkg::C_CCNT] + 32'h1);
		end
		if (q.run) begin
			d.icl = d.icl || clk_loss;
			d.isl = d.isl || cur[edps_pkg::I_SYNC];
		end
		if (tick && q.run) begin
			if (q.ie || err_now) begin
				d.cnt[edps_pkg::C_EI] = 32'(q.cnt[edps_pkg::C_EI] + 32'h1);
			end else begin
				d.cnt[edps_pkg::C_EFI] = 32'(q.cnt[edps_pkg::C_EFI] + 32'h1);
			end
			if (q.icl || clk_loss) begin
				d.cnt[edps_pkg::C_CLI] = 32'(q.cnt[edps_pkg::C_CLI] + 32'h1);
			end
			if (q.isl || cur[edps_pkg::I_SYNC]) begin
				d.cnt[edps_pkg::C_SLI] = 32'(q.cnt[edps_pkg::C_SLI] + 32'h1);
			end
			d.lerr = q.ie || err_now;
			d.ie = 1'b0;
			d.icl = 1'b0;
			d.isl = 1'b0;
			d.cnt[edps_pkg::C_ELAP] = 32'(q.cnt[edps_pkg::C_ELAP] + 32'h1);
			if ((q.period != 32'h00000000) && (32'(q.cnt[edps_pkg::C_ELAP]
				+ 32'h1) == q.period)) begin
				d.run = 1'b0;
				d.state = edps_pkg::S_IDLE;
				ev[edps_pkg::IRQ_DONE] = 1'b1;
			end
		end

		if (stop) begin
			d.run = 1'b0;
			d.state = edps_pkg::S_IDLE;
		end
		if (start) begin
			for (int i = 0; i < edps_pkg::C_STIME; i++) begin
				if (i != edps_pkg::C_FREQ) begin
					d.cnt[i] = 32'h00000000;
				end
			end
			d.cnt[edps_pkg::C_STIME] = q.tms;
			d.ie = 1'b0;
			d.icl = 1'b0;
			d.isl = 1'b0;
			d.lerr = 1'b0;
			d.eff = {1'b0, dlen};
			d.run = cfg_ok;
			d.state = cfg_ok ? edps_pkg::S_SETUP : edps_pkg::S_IDLE;
			ev[edps_pkg::IRQ_CFG] = !cfg_ok;
		end

		d.hist = (hrst ? 3'h0 : q.hist) | cur;
		d.status = (q.status & ~w1c) | ev;
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			q <= edps_pkg::ST_RST;
		end else if (CE) begin
			q <= d;
		end
	end

	// A frozen block must stall the bus rather than drop transfers
	assign HREADYOUT = CE;
	assign HRESP = 1'b0;
	assign HRDATA = q.rdata;
	assign IRQ = |(q.status & q.mask);
	assign SYNC_OK = q.state == edps_pkg::S_SYNC;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);

	a_frame_gain: assert property (CE && q.state == edps_pkg::S_HUNT
		&& !quick && hit |=> q.state == edps_pkg::S_ALIGN)
		else $error("frame hit did not start alignment");
	a_quick_sync: assert property (CE && q.state == edps_pkg::S_HUNT
		&& quick |=> SYNC_OK && q.ptr == 16'h0000)
		else $error("quick mode did not sync at pattern start");
	a_mode_block: assert property (CE && start && !mode_ok
		|=> q.state == edps_pkg::S_IDLE && !q.run)
		else $error("forbidden sync method was started");
	a_flen_legal: assert property (q.state == edps_pkg::S_HUNT
		&& !quick |-> flen_ok)
		else $error("illegal frame length in hunt");
	a_combo_match: assert property (hit && !quick
		&& q.cfg[edps_pkg::CF_COMBO] |-> q.sr[1:0] == {2{q.fpat[0]}})
		else $error("combined frame match ignores channel copies");
	a_pos_legal: assert property (q.state == edps_pkg::S_HUNT
		&& !quick |-> pos_ok)
		else $error("frame position out of range in hunt");
	a_repeat_len: assert property (q.state == edps_pkg::S_HUNT
		|-> q.eff >= edps_pkg::MIN_DET && q.eff >= {1'b0, dlen})
		else $error("detection length below minimum");
	a_hist_reset: assert property (CE && hrst
		|=> (q.hist & ~$past(cur)) == 3'h0)
		else $error("history reset left stale history");
	a_hist_keep: assert property (CE && !hrst && cur[edps_pkg::I_CLK]
		|=> q.hist[edps_pkg::I_CLK]
		##1 (q.hist[edps_pkg::I_CLK] || $past(hrst)))
		else $error("clock loss history not latched");
	a_ei_count: assert property (CE && tick && q.run && q.ie
		|=> q.cnt[edps_pkg::C_EI] == $past(q.cnt[edps_pkg::C_EI]) + 32'h1
		|| $past(start))
		else $error("errored interval not counted");
	a_start_clear: assert property (CE && start
		|=> q.cnt[edps_pkg::C_TOT] == 32'h0 && q.cnt[edps_pkg::C_EI] == 32'h0
		&& q.cnt[edps_pkg::C_CCNT] == 32'h0)
		else $error("start did not clear counters");
endmodule
